// [shared/tild_pkg.sv]
// Constants, field layout and carrier types of the trigger front end.
// Assumes a single 40 MHz clock and an AXI4-Lite register port.
package tild_pkg;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned PREC_RES_PS   = 250;
  localparam int unsigned SYNC_RES_PS   = 4000;
  localparam int unsigned PREC_RES_CYC  = (PREC_RES_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SYNC_RES_CYC  = (SYNC_RES_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam int unsigned NUM_BP   = 2;
  localparam int unsigned SAMPLE_W = 16;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LEVEL  = 8'h04;
  localparam logic [7:0] ADDR_RLEVEL = 8'h08;
  localparam logic [7:0] ADDR_BASE   = 8'h0C;
  localparam logic [7:0] ADDR_RECLEN = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_TPOS   = 8'h18;

  localparam int unsigned CTRL_PREC_POL = 0;
  localparam int unsigned CTRL_SYNC_POL = 1;
  localparam int unsigned CTRL_DIR_LSB  = 2;
  localparam int unsigned CTRL_MASK_LSB = 4;
  localparam int unsigned CTRL_OUT_SEL  = 6;
  localparam int unsigned CTRL_LVL_FALL = 7;
  localparam int unsigned CTRL_BASE_EN  = 8;
  localparam int unsigned CTRL_CH_LSB   = 9;
  localparam int unsigned CTRL_SRC_LSB  = 11;
  localparam int unsigned CTRL_OUT_EN   = 13;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] LEVEL_RST  = 16'h0000;
  localparam logic [15:0] RLEVEL_RST = 16'h0000;
  localparam logic [15:0] BASE_RST   = 16'h0000;
  localparam logic [15:0] RECLEN_RST = 16'h0100;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SRC_PREC, SRC_SYNC, SRC_BACKPLANE, SRC_LEVEL} tild_src_e;

  typedef struct packed {
    logic              prec;
    logic              sync;
    logic [NUM_BP-1:0] bp_in;
  } tild_pins_s;

  typedef struct packed {
    logic [NUM_BP-1:0] out;
    logic [NUM_BP-1:0] oe;
  } tild_bp_s;
endpackage

// [design/tild_edge_sync.sv]
// Two-stage synchroniser with polarity-selectable edge pulse.
// Assumes din is asynchronous to clk and fall is a same-clock level.
`timescale 1ns/1ps
module tild_edge_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  input  wire logic fall,
  output logic      lvl,
  output logic      pulse
);
  logic meta_r;
  logic sync_r;
  logic pulse_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  // Edge seen between sync_r and the registered level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl     <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      lvl     <= sync_r;
      pulse_r <= (sync_r != lvl) && (fall ? !sync_r : sync_r);
    end
  end

  assign pulse = pulse_r;

  a_pulse_single: assert property (@(posedge clk) disable iff (!rst_n) pulse_r |=> !pulse_r)
    else $error("edge pulse longer than one cycle");
  a_pulse_cause: assert property (@(posedge clk) disable iff (!rst_n)
    pulse_r |-> $past(sync_r) == !$past(fall) && lvl != $past(lvl))
    else $error("edge pulse without matching edge");
endmodule

// [design/tild_top.sv]
// Trigger front end: external edge inputs, backplane ports, level trigger.
// Assumes AXI4-Lite master on aclk; trigger pins asynchronous to aclk.
`timescale 1ns/1ps
module tild_top #(
  parameter int unsigned NCH    = 4,
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [ADDR_W-1:0]                   awaddr,
  input  wire logic                                awvalid,
  output logic                                     awready,
  input  wire logic [31:0]                         wdata,
  input  wire logic [3:0]                          wstrb,
  input  wire logic                                wvalid,
  output logic                                     wready,
  output logic [1:0]                               bresp,
  output logic                                     bvalid,
  input  wire logic                                bready,
  input  wire logic [ADDR_W-1:0]                   araddr,
  input  wire logic                                arvalid,
  output logic                                     arready,
  output logic [31:0]                              rdata,
  output logic [1:0]                               rresp,
  output logic                                     rvalid,
  input  wire logic                                rready,
  input  wire tild_pkg::tild_pins_s                pins,
  output tild_pkg::tild_bp_s                       bp_drv,
  input  wire logic [NCH-1:0][tild_pkg::SAMPLE_W-1:0] sample_data,
  input  wire logic                                sample_valid,
  output logic                                     trig_event,
  output logic                                     record_busy
);
  localparam int unsigned NB  = tild_pkg::NUM_BP;
  localparam int unsigned CHW = 2;

  logic [31:0] ctrl_r;
  logic [15:0] level_r;
  logic [15:0] rlevel_r;
  logic [15:0] base_r;
  logic [15:0] reclen_r;
  logic [31:0] tpos_r;
  logic [31:0] samp_cnt_r;
  logic [15:0] rec_cnt_r;
  logic        busy_r;
  logic        armed_r;
  logic        trig_r;
  logic [NB-1:0] bp_out_r;
  logic [NB-1:0] bp_oe_r;
  logic        bp_prev_r;
  logic        bp_pulse_r;

  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [1:0]  bresp_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;

  // Control fields
  logic                prec_fall;
  logic                sync_fall;
  logic [NB-1:0]       bp_dir;
  logic [NB-1:0]       bp_mask;
  logic                out_sel;
  logic                lvl_fall;
  logic                base_en;
  logic [CHW-1:0]      ch_sel;
  tild_pkg::tild_src_e src;
  logic                out_en;

  assign prec_fall = ctrl_r[tild_pkg::CTRL_PREC_POL];
  assign sync_fall = ctrl_r[tild_pkg::CTRL_SYNC_POL];
  assign bp_dir    = ctrl_r[tild_pkg::CTRL_DIR_LSB +: NB];
  assign bp_mask   = ctrl_r[tild_pkg::CTRL_MASK_LSB +: NB];
  assign out_sel   = ctrl_r[tild_pkg::CTRL_OUT_SEL];
  assign lvl_fall  = ctrl_r[tild_pkg::CTRL_LVL_FALL];
  assign base_en   = ctrl_r[tild_pkg::CTRL_BASE_EN];
  assign ch_sel    = ctrl_r[tild_pkg::CTRL_CH_LSB +: CHW];
  assign src       = tild_pkg::tild_src_e'(ctrl_r[tild_pkg::CTRL_SRC_LSB +: 2]);
  assign out_en    = ctrl_r[tild_pkg::CTRL_OUT_EN];

  // Front-panel inputs and backplane port synchronisers
  logic          prec_pulse;
  logic          sync_pulse;
  logic [NB-1:0] bp_lvl;

  tild_edge_sync u_prec (
    .clk   (aclk),
    .rst_n (aresetn),
    .din   (pins.prec),
    .fall  (prec_fall),
    .lvl   (),
    .pulse (prec_pulse)
  );

  tild_edge_sync u_sync (
    .clk   (aclk),
    .rst_n (aresetn),
    .din   (pins.sync),
    .fall  (sync_fall),
    .lvl   (),
    .pulse (sync_pulse)
  );

  for (genvar i = 0; i < NB; i++) begin : g_bp
    tild_edge_sync u_bp (
      .clk   (aclk),
      .rst_n (aresetn),
      .din   (pins.bp_in[i]),
      .fall  (1'b0),
      .lvl   (bp_lvl[i]),
      .pulse ()
    );
  end

  // Masked OR of backplane ports, independent of the output path
  logic bp_or;
  assign bp_or = |(bp_mask & bp_lvl);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bp_prev_r  <= 1'b0;
      bp_pulse_r <= 1'b0;
    end else begin
      bp_prev_r  <= bp_or;
      bp_pulse_r <= bp_or && !bp_prev_r;
    end
  end

  // Level trigger compare
  logic signed [16:0] smp;
  logic signed [16:0] rel;
  logic signed [16:0] lvl_s;
  logic signed [16:0] rlvl_s;
  logic               beyond;
  logic               rearm;
  logic               lvl_hit;

  assign smp    = 17'(signed'(sample_data[ch_sel]));
  assign rel    = base_en ? smp - 17'(signed'(base_r)) : smp;
  assign lvl_s  = 17'(signed'(level_r));
  assign rlvl_s = 17'(signed'(rlevel_r));
  assign beyond = lvl_fall ? (rel < lvl_s) : (rel > lvl_s);
  assign rearm  = lvl_fall ? (rel > rlvl_s) : (rel < rlvl_s);
  assign lvl_hit = sample_valid && armed_r && beyond;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_r <= 1'b0;
    end else if (sample_valid) begin
      if (lvl_hit) begin
        armed_r <= 1'b0;
      end else if (rearm) begin
        armed_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_cnt_r <= 32'h0000_0000;
    end else if (sample_valid) begin
      samp_cnt_r <= samp_cnt_r + 32'h0000_0001;
    end
  end

  // Source select and record gating
  logic sel_pulse;
  logic accept;

  always_comb begin
    unique case (src)
      tild_pkg::SRC_PREC:      sel_pulse = prec_pulse;
      tild_pkg::SRC_SYNC:      sel_pulse = sync_pulse;
      tild_pkg::SRC_BACKPLANE: sel_pulse = bp_pulse_r;
      tild_pkg::SRC_LEVEL:     sel_pulse = lvl_hit;
    endcase
  end

  assign accept = sel_pulse && !busy_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r    <= 1'b0;
      rec_cnt_r <= 16'h0000;
      trig_r    <= 1'b0;
      tpos_r    <= 32'h0000_0000;
    end else begin
      trig_r <= accept;
      if (accept) begin
        busy_r    <= 1'b1;
        rec_cnt_r <= reclen_r;
        tpos_r    <= samp_cnt_r;
      end else if (busy_r && sample_valid) begin
        if (rec_cnt_r <= 16'h0001) begin
          busy_r <= 1'b0;
        end
        rec_cnt_r <= rec_cnt_r - 16'h0001;
      end
    end
  end

  // Backplane drive: per-port direction, chosen output port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bp_out_r <= '0;
      bp_oe_r  <= '0;
    end else begin
      bp_oe_r <= bp_dir;
      for (int i = 0; i < NB; i++) begin
        bp_out_r[i] <= accept && out_en && bp_dir[i] && (out_sel == i[0]);
      end
    end
  end

  assign bp_drv.out  = bp_out_r;
  assign bp_drv.oe   = bp_oe_r;
  assign trig_event  = trig_r;
  assign record_busy = busy_r;

  // AXI4-Lite write channel
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic        do_write;
  logic [31:0] wr_val;
  assign do_write = !awready_r && !wready_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= tild_pkg::RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (awvalid && awready_r) begin
        awready_r <= 1'b0;
        aw_addr_r <= awaddr;
      end else if (bvalid_r && bready) begin
        awready_r <= 1'b1;
      end
      if (wvalid && wready_r) begin
        wready_r <= 1'b0;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end else if (bvalid_r && bready) begin
        wready_r <= 1'b1;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (aw_addr_r[7:0] <= tild_pkg::ADDR_RECLEN && aw_addr_r[1:0] == 2'h0)
                    ? tild_pkg::RESP_OKAY : tild_pkg::RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign wr_val = merge(32'h0000_0000, w_data_r, w_strb_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= tild_pkg::CTRL_RST;
      level_r  <= tild_pkg::LEVEL_RST;
      rlevel_r <= tild_pkg::RLEVEL_RST;
      base_r   <= tild_pkg::BASE_RST;
      reclen_r <= tild_pkg::RECLEN_RST;
    end else if (do_write) begin
      unique case (aw_addr_r[7:0])
        tild_pkg::ADDR_CTRL:   ctrl_r   <= merge(ctrl_r, w_data_r, w_strb_r);
        tild_pkg::ADDR_LEVEL:  level_r  <= 16'(merge({16'h0000, level_r}, wr_val, w_strb_r));
        tild_pkg::ADDR_RLEVEL: rlevel_r <= 16'(merge({16'h0000, rlevel_r}, wr_val, w_strb_r));
        tild_pkg::ADDR_BASE:   base_r   <= 16'(merge({16'h0000, base_r}, wr_val, w_strb_r));
        tild_pkg::ADDR_RECLEN: reclen_r <= 16'(merge({16'h0000, reclen_r}, wr_val, w_strb_r));
        default: ;
      endcase
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= tild_pkg::RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= tild_pkg::RESP_OKAY;
      unique case (araddr[7:0])
        tild_pkg::ADDR_CTRL:   rdata_r <= ctrl_r;
        tild_pkg::ADDR_LEVEL:  rdata_r <= {16'h0000, level_r};
        tild_pkg::ADDR_RLEVEL: rdata_r <= {16'h0000, rlevel_r};
        tild_pkg::ADDR_BASE:   rdata_r <= {16'h0000, base_r};
        tild_pkg::ADDR_RECLEN: rdata_r <= {16'h0000, reclen_r};
        tild_pkg::ADDR_STATUS: rdata_r <= {28'h0000000, bp_lvl, armed_r, busy_r};
        tild_pkg::ADDR_TPOS:   rdata_r <= tpos_r;
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= tild_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_no_retrig: assert property (trig_r |-> !$past(busy_r))
    else $error("trigger accepted during a record");
  a_event_busy: assert property (trig_r |-> busy_r && rec_cnt_r == reclen_r)
    else $error("accepted trigger did not start a record");
  a_level_fire: assert property (src == tild_pkg::SRC_LEVEL && lvl_hit && !busy_r |=> trig_r)
    else $error("level crossing missed");
  a_hyst_rearm: assert property ($rose(armed_r) |-> $past(sample_valid && rearm))
    else $error("level trigger rearmed without crossing reset level");
  a_fire_disarm: assert property (lvl_hit |=> !armed_r)
    else $error("level trigger still armed after firing");
  a_bp_or_edge: assert property (bp_pulse_r |-> $past(bp_or) && !$past(bp_or, 2))
    else $error("backplane pulse without rising masked OR");
  a_out_port: assert property (|bp_out_r |-> trig_r && (bp_out_r & ~bp_oe_r) == '0)
    else $error("trigger output on wrong or input port");
  a_tpos_cap: assert property (trig_r |-> tpos_r == $past(samp_cnt_r))
    else $error("trigger position not captured");
  a_write_resp: assert property ($rose(bvalid_r) |-> $past(!awready_r && !wready_r))
    else $error("write response before address and data");

  c_level_trig: cover property (src == tild_pkg::SRC_LEVEL && trig_r);
  c_discarded: cover property (sel_pulse && busy_r);
  c_bp_trig: cover property (src == tild_pkg::SRC_BACKPLANE && trig_r && |bp_out_r);
  c_prec_fall: cover property (prec_fall && prec_pulse);
endmodule

// [dv/tild_ext_model.sv]
// Far side of the trigger front end: remote trigger sources and backplane lines.
// Assumes the testbench calls set_line; lines change between clock edges.
`timescale 1ns/1ps
module tild_ext_model (
  input  wire tild_pkg::tild_bp_s bp_drv,
  input  wire logic               aclk,
  output tild_pkg::tild_pins_s    pins
);
  // Bits 3 precision, 2 sync, 1..0 backplane ports
  logic [3:0] ext = 4'h0;

  assign pins.prec = ext[3];
  assign pins.sync = ext[2];
  // A port that the device drives shows its own level
  assign pins.bp_in = (bp_drv.oe & bp_drv.out) | (~bp_drv.oe & ext[1:0]);

  task automatic set_line(input int idx, input logic v, input int dly);
    repeat (dly) @(posedge aclk);
    #7;  // Asynchronous to the sampling edge
    ext[idx] = v;
  endtask
endmodule

// [dv/tb_trigger_input_and_level_detect.sv]
// Self-checking bench: register port, level trigger, pin and backplane triggers.
// Assumes tild_top with NCH 4 and the partner model on the trigger pins.
`timescale 1ns/1ps
module tb_trigger_input_and_level_detect;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [1:0]  br;
    logic [31:0] rd;
    logic [1:0]  rr;
  } tild_row_s;
  localparam logic [1:0] OK = tild_pkg::RESP_OKAY;
  localparam logic [1:0] ER = tild_pkg::RESP_SLVERR;
  logic                 aclk = 1'b0;
  logic                 aresetn = 1'b0;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata, rdata, d;
  logic [3:0]           wstrb;
  logic [1:0]           bresp, rresp, r;
  logic                 awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready, sample_valid, trig_event, record_busy;
  logic [3:0][15:0]     sample_data;
  tild_pkg::tild_pins_s pins;
  tild_pkg::tild_bp_s   bp_drv;
  int                   error_cnt, compares, cyc, trig_cnt, t0;
  int                   oc [2];
  tild_row_s rows [7] = '{
    '{8'h04, 32'h0000_8001, OK, 32'h0000_8001, OK},
    '{8'h08, 32'hFFFF_F000, OK, 32'h0000_F000, OK},
    '{8'h0C, 32'h0000_1000, OK, 32'h0000_1000, OK},
    '{8'h10, 32'h0000_0004, OK, 32'h0000_0004, OK},
    '{8'h14, 32'h0000_00FF, ER, 32'h0000_0000, OK},
    '{8'h1C, 32'h0000_1234, ER, 32'h0000_0000, ER},
    '{8'h00, 32'h0000_0008, OK, 32'h0000_0008, OK}};

  always #12.5 aclk = ~aclk;

  tild_top DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pins(pins),
    .bp_drv(bp_drv), .sample_data(sample_data), .sample_valid(sample_valid),
    .trig_event(trig_event), .record_busy(record_busy));

  tild_ext_model u_src (.bp_drv(bp_drv), .aclk(aclk), .pins(pins));

  always @(posedge aclk) begin
    cyc++;
    if (trig_event === 1'b1) trig_cnt++;
    if (bp_drv.out[0] === 1'b1) oc[0]++;
    if (bp_drv.out[1] === 1'b1) oc[1]++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic smp(input int ch, input logic [15:0] v);
    logic [3:0][15:0] s;
    s = '0;
    s[ch] = v;
    @(posedge aclk);
    sample_data <= s;
    sample_valid <= 1'b1;
    @(posedge aclk);
    sample_valid <= 1'b0;
  endtask

  // Count of trigger pulses since the previous call
  task automatic tchk(input int e);
    repeat (8) @(posedge aclk);
    chk(32'(trig_cnt - t0), 32'(e), "trigger count");
    t0 = trig_cnt;
  endtask

  // Zero samples until the record closes
  task automatic end_rec;
    int n;
    n = 0;
    while (record_busy === 1'b1 && n < 40) begin
      smp(0, 16'h0000);
      n++;
    end
    chk(32'(record_busy), 32'h0, "record end");
  endtask

  task print_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, sample_valid} = '0;
    sample_data = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk(32'({trig_event, record_busy, bp_drv}), 32'h0, "reset outputs");
    rd(tild_pkg::ADDR_CTRL, d, r);
    chk(d, 32'h0000_0000, "ctrl reset");
    rd(tild_pkg::ADDR_RECLEN, d, r);
    chk(d, 32'h0000_0100, "reclen reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, r);
      chk(32'(r), 32'(rows[i].br), "write resp");
      rd(rows[i].a, d, r);
      chk(d, rows[i].rd, "read data");
      chk(32'(r), 32'(rows[i].rr), "read resp");
    end
    chk(32'(bp_drv.oe), 32'h2, "port direction");
    // Rising level trigger on channel 2
    wr(tild_pkg::ADDR_LEVEL, 32'h0000_1000, r);
    wr(tild_pkg::ADDR_CTRL, 32'h0000_1C00, r);
    @(posedge aclk);
    chk(32'(bp_drv.oe), 32'h0, "port direction");
    smp(1, 16'h7000);
    tchk(0);
    smp(2, 16'hE000);
    smp(2, 16'h1000);
    tchk(0);
    smp(2, 16'h2000);
    tchk(1);
    chk(32'(record_busy), 32'h1, "record busy");
    // Fourth valid sample since reset, counted from zero
    rd(tild_pkg::ADDR_TPOS, d, r);
    chk(d, 32'h0000_0003, "trigger position");
    smp(2, 16'hE000);
    smp(2, 16'h2000);
    tchk(0);
    end_rec;
    smp(2, 16'h2000);
    tchk(0);
    smp(2, 16'hE000);
    smp(2, 16'h2000);
    tchk(1);
    end_rec;
    // Relative to the baseline target
    wr(tild_pkg::ADDR_CTRL, 32'h0000_1D00, r);
    smp(2, 16'hE000);
    smp(2, 16'h1800);
    tchk(0);
    smp(2, 16'h2800);
    tchk(1);
    end_rec;
    // Falling crossing
    wr(tild_pkg::ADDR_LEVEL, 32'h0000_F000, r);
    wr(tild_pkg::ADDR_RLEVEL, 32'h0000_1000, r);
    wr(tild_pkg::ADDR_CTRL, 32'h0000_1C80, r);
    smp(2, 16'h2000);
    smp(2, 16'hF000);
    tchk(0);
    smp(2, 16'hE000);
    tchk(1);
    end_rec;
    // Precision then sync pin, both polarities, output on port 1
    for (int k = 0; k < 2; k++) begin
      wr(tild_pkg::ADDR_CTRL, 32'h0000_2048 | (32'(k) << 11), r);
      u_src.set_line(3 - k, 1'b1, k * 5);
      tchk(1);
      end_rec;
      u_src.set_line(3 - k, 1'b0, 0);
      tchk(0);
      wr(tild_pkg::ADDR_CTRL, 32'h0000_2048 | (32'(k) << 11) | (32'h1 << k), r);
      u_src.set_line(3 - k, 1'b1, 0);
      tchk(0);
      u_src.set_line(3 - k, 1'b0, 3);
      tchk(1);
      end_rec;
    end
    // Port 1 in, port 0 drives the trigger out
    wr(tild_pkg::ADDR_CTRL, 32'h0000_3024, r);
    @(posedge aclk);
    chk(32'(bp_drv.oe), 32'h1, "port direction");
    u_src.set_line(1, 1'b1, 0);
    tchk(1);
    end_rec;
    u_src.set_line(1, 1'b0, 0);
    wr(tild_pkg::ADDR_CTRL, 32'h0000_1010, r);
    u_src.set_line(1, 1'b1, 0);
    tchk(0);
    u_src.set_line(0, 1'b1, 0);
    tchk(1);
    end_rec;
    chk(32'(oc[1]), 32'h4, "port 1 outputs");
    chk(32'(oc[0]), 32'h1, "port 0 outputs");
    print_verdict;
  end
endmodule
